// file: design/burst_prot_ctrl.v
/*
 burst mode and protection control of a quasi-resonant flyback controller.
 assumes comparator levels arrive on core_clk edges and that an outer
 normal-mode generator supplies norm_gate_on / norm_gate_off pulses.
*/
`timescale 1ns/1ps
`include "burst_prot_map.vh"

module burst_prot_ctrl #(
    parameter OVERLOAD_CYC = `OVERLOAD_BLANK_CYC,
    parameter ENTRY_CYC = `ENTRY_BLANK_CYC,
    parameter MAX_ON = `MAX_ON_CYC
) (
    // clock and reset
    input wire core_clk,
    input wire resetn,
    // feedback comparators
    input wire fb_below_entry,
    input wire fb_above_upper,
    input wire fb_below_lower,
    input wire fb_above_exit,
    input wire fb_pulled_high,
    // current sense and zero crossing comparators
    input wire cs_above_burst_limit,
    input wire cs_above_short_winding,
    input wire zc_above_ovp,
    // supply and temperature comparators
    input wire vcc_below_turnoff,
    input wire vcc_above_turnon,
    input wire vcc_overvoltage,
    input wire over_temp,
    // normal-mode switching requests and counter
    input wire norm_gate_on,
    input wire norm_gate_off,
    input wire [2:0] updn_count,
    // outputs
    output reg gate_drive,
    output reg startup_cell_en,
    output reg burst_active,
    output reg bias_en,
    output reg updn_load,
    output reg [2:0] updn_load_val,
    output reg latched_off,
    output reg auto_restart
);

    localparam NSYNC = 12;
    localparam PER = `BURST_PERIOD_CYC;
    localparam HALF = PER / 2;

    // two-stage synchronisers, one per comparator
    wire [NSYNC-1:0] raw;
    reg [NSYNC-1:0] s1_q;
    reg [NSYNC-1:0] s2_q;
    assign raw = {fb_below_entry, fb_above_upper, fb_below_lower,
        fb_above_exit, fb_pulled_high, cs_above_burst_limit,
        cs_above_short_winding, zc_above_ovp, vcc_below_turnoff,
        vcc_above_turnon, vcc_overvoltage, over_temp};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge core_clk) begin
                if (!resetn) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate

    wire entry_s = s2_q[11];
    wire upper_s = s2_q[10];
    wire lower_s = s2_q[9];
    wire exit_s = s2_q[8];
    wire olhigh_s = s2_q[7];
    wire csb_s = s2_q[6];
    wire cssw_s = s2_q[5];
    wire ovp_s = s2_q[4];
    wire vlow_s = s2_q[3];
    wire von_s = s2_q[2];
    wire vovp_s = s2_q[1];
    wire otemp_s = s2_q[0];

    reg [2:0] mode_q;
    reg [2:0] mode_d;
    reg [24:0] entry_cnt_q;
    reg [24:0] ol_cnt_q;
    reg [15:0] ovp_cnt_q;
    reg [15:0] tmr_q;
    reg [15:0] on_cnt_q;

    wire entry_done = (entry_cnt_q >= ENTRY_CYC);
    wire ol_done = (ol_cnt_q >= OVERLOAD_CYC);
    wire ovp_done = (ovp_cnt_q >= `OVP_BLANK_CYC);
    wire tmr_wrap = (tmr_q == PER - 1);

    // fault sorting
    wire ar_fault = vlow_s | vovp_s | ol_done | otemp_s;
    wire lo_fault = ovp_done | (gate_drive & cssw_s);

    always @* begin
        mode_d = mode_q;
        case (mode_q)
            `MODE_OFF: begin
                if (von_s && !vovp_s && !otemp_s) begin
                    mode_d = `MODE_NORMAL;
                end
            end
            `MODE_NORMAL: begin
                if (entry_s && updn_count == `UPDN_BURST_VAL && entry_done) begin
                    mode_d = `MODE_BURST_PAUSE;
                end
            end
            `MODE_BURST_RUN: begin
                if (exit_s) begin
                    mode_d = `MODE_NORMAL;
                end else if (lower_s) begin
                    mode_d = `MODE_BURST_PAUSE;
                end
            end
            `MODE_BURST_PAUSE: begin
                if (exit_s) begin
                    mode_d = `MODE_NORMAL;
                end else if (upper_s) begin
                    mode_d = `MODE_BURST_RUN;
                end
            end
            `MODE_LATCHED: begin
                mode_d = `MODE_LATCHED;
            end
            default: begin
                mode_d = `MODE_OFF;
            end
        endcase
        // faults override any switching state
        if (mode_q != `MODE_LATCHED && mode_q != `MODE_OFF) begin
            if (lo_fault) begin
                mode_d = `MODE_LATCHED;
            end else if (ar_fault) begin
                mode_d = `MODE_OFF;
            end
        end
        if (mode_q == `MODE_OFF && lo_fault) begin
            mode_d = `MODE_LATCHED;
        end
    end

    wire in_burst = (mode_q == `MODE_BURST_RUN) ||
        (mode_q == `MODE_BURST_PAUSE);
    wire running = (mode_q == `MODE_NORMAL) || in_burst;
    wire leave_burst = in_burst && mode_d == `MODE_NORMAL;

    // burst turn-off: current limit or half period, first wins
    wire burst_off = csb_s || (tmr_q >= HALF - 1);
    wire max_on_hit = (on_cnt_q >= MAX_ON - 1);

    // mode register
    always @(posedge core_clk) begin
        if (!resetn) begin
            mode_q <= `MODE_OFF;
        end else begin
            mode_q <= mode_d;
        end
    end

    // entry blanking restarts whenever a condition drops
    always @(posedge core_clk) begin
        if (!resetn) begin
            entry_cnt_q <= 25'h0;
        end else if (mode_q == `MODE_NORMAL && entry_s &&
            updn_count == `UPDN_BURST_VAL) begin
            if (!entry_done) begin
                entry_cnt_q <= entry_cnt_q + 25'h1;
            end
        end else begin
            entry_cnt_q <= 25'h0;
        end
    end

    // overload blanking, not counted in burst
    always @(posedge core_clk) begin
        if (!resetn) begin
            ol_cnt_q <= 25'h0;
        end else if (running && olhigh_s && !in_burst) begin
            if (!ol_done) begin
                ol_cnt_q <= ol_cnt_q + 25'h1;
            end
        end else begin
            ol_cnt_q <= 25'h0;
        end
    end

    // ovp only counts while the switch is off
    always @(posedge core_clk) begin
        if (!resetn) begin
            ovp_cnt_q <= 16'h0;
        end else if (running && !gate_drive && ovp_s) begin
            if (!ovp_done) begin
                ovp_cnt_q <= ovp_cnt_q + 16'h1;
            end
        end else begin
            ovp_cnt_q <= 16'h0;
        end
    end

    // fixed-frequency burst timer
    always @(posedge core_clk) begin
        if (!resetn) begin
            tmr_q <= 16'h0;
        end else if (mode_q == `MODE_BURST_RUN && !tmr_wrap) begin
            tmr_q <= tmr_q + 16'h1;
        end else begin
            tmr_q <= 16'h0;
        end
    end

    // on time, any mode
    always @(posedge core_clk) begin
        if (!resetn) begin
            on_cnt_q <= 16'h0;
        end else if (gate_drive) begin
            on_cnt_q <= on_cnt_q + 16'h1;
        end else begin
            on_cnt_q <= 16'h0;
        end
    end

    // gate flip-flop, any stop beats any start while the gate is on
    always @(posedge core_clk) begin
        if (!resetn) begin
            gate_drive <= 1'b0;
        end else if (mode_d == `MODE_OFF || mode_d == `MODE_LATCHED ||
            mode_d == `MODE_BURST_PAUSE || max_on_hit) begin
            gate_drive <= 1'b0;
        end else if (mode_q == `MODE_BURST_RUN) begin
            if (gate_drive && burst_off) begin
                gate_drive <= 1'b0;
            end else if (tmr_wrap) begin
                gate_drive <= 1'b1;
            end
        end else if (mode_q == `MODE_NORMAL) begin
            if (gate_drive && norm_gate_off) begin
                gate_drive <= 1'b0;
            end else if (norm_gate_on) begin
                gate_drive <= 1'b1;
            end
        end
    end

    // startup cell hysteresis, off while running
    always @(posedge core_clk) begin
        if (!resetn) begin
            startup_cell_en <= 1'b0;
        end else if (mode_d == `MODE_OFF || mode_d == `MODE_LATCHED) begin
            if (vlow_s) begin
                startup_cell_en <= 1'b1;
            end else if (von_s) begin
                startup_cell_en <= 1'b0;
            end
        end else begin
            startup_cell_en <= 1'b0;
        end
    end

    // burst flag covers run and pause
    always @(posedge core_clk) begin
        if (!resetn) begin
            burst_active <= 1'b0;
        end else begin
            burst_active <= (mode_d == `MODE_BURST_RUN) ||
                (mode_d == `MODE_BURST_PAUSE);
        end
    end

    // bias dropped while paused saves supply current
    always @(posedge core_clk) begin
        if (!resetn) begin
            bias_en <= 1'b0;
        end else begin
            bias_en <= (mode_d != `MODE_BURST_PAUSE) &&
                (mode_d != `MODE_OFF) && (mode_d != `MODE_LATCHED);
        end
    end

    // one-cycle load strobe on burst exit
    always @(posedge core_clk) begin
        if (!resetn) begin
            updn_load <= 1'b0;
        end else begin
            updn_load <= leave_burst;
        end
    end

    // load value
    always @(posedge core_clk) begin
        if (!resetn) begin
            updn_load_val <= 3'h0;
        end else begin
            updn_load_val <= `UPDN_EXIT_VAL;
        end
    end

    // latched off, left only by reset
    always @(posedge core_clk) begin
        if (!resetn) begin
            latched_off <= 1'b0;
        end else begin
            latched_off <= (mode_d == `MODE_LATCHED);
        end
    end

    // auto-restart waits in off
    always @(posedge core_clk) begin
        if (!resetn) begin
            auto_restart <= 1'b0;
        end else begin
            auto_restart <= (mode_d == `MODE_OFF);
        end
    end

endmodule

// file: design/burst_prot_map.vh
/*
 burst mode and protection control: timing counts, counter values and
 mode codes. assumes core_clk at 200 MHz.
*/
`ifndef BURST_PROT_MAP_VH
`define BURST_PROT_MAP_VH

`define CLK_MHZ 200
// burst timer period 20 us (50 kHz)
`define BURST_PERIOD_NS 20000
`define BURST_PERIOD_CYC (`BURST_PERIOD_NS * `CLK_MHZ / 1000)
// overload blanking 24 ms
`define OVERLOAD_BLANK_MS 24
`define OVERLOAD_BLANK_CYC (`OVERLOAD_BLANK_MS * `CLK_MHZ * 1000)
// burst entry blanking, output overvoltage blanking, max on time: no figure
`define ENTRY_BLANK_CYC 20000
`define OVP_BLANK_CYC 200
`define MAX_ON_CYC 6000
`define UPDN_BURST_VAL 3'h7
`define UPDN_EXIT_VAL 3'h1

`define MODE_OFF 3'h0
`define MODE_NORMAL 3'h1
`define MODE_BURST_RUN 3'h2
`define MODE_BURST_PAUSE 3'h3
`define MODE_LATCHED 3'h4

`endif

// file: tb/burst_prot_monitor.sv
/*
 checker for the burst and protection controller ports.
 assumes a bind onto burst_prot_ctrl, single core_clk domain.
*/
`timescale 1ns/1ps
module burst_prot_monitor #(
    parameter MAX_ON = 6000
) (
    // clock and reset
    input wire core_clk,
    input wire resetn,
    // comparators
    input wire fb_above_upper,
    input wire cs_above_short_winding,
    input wire vcc_below_turnoff,
    // outputs
    input wire gate_drive,
    input wire startup_cell_en,
    input wire burst_active,
    input wire bias_en,
    input wire updn_load,
    input wire [2:0] updn_load_val,
    input wire latched_off
);
    reg [15:0] on_q;
    reg [15:0] per_q;
    reg run_q;
    // period only judged between two rises of one run
    always @(posedge core_clk) begin
        if (!resetn) begin
            on_q <= 16'h0;
            per_q <= 16'h0;
            run_q <= 1'b0;
        end else begin
            on_q <= gate_drive ? on_q + 16'h1 : 16'h0;
            per_q <= $rose(gate_drive) ? 16'h1 : per_q + 16'h1;
            run_q <= burst_active && bias_en && (run_q || $rose(gate_drive));
        end
    end
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_duty; burst_active |-> on_q <= 16'h7d0; endproperty
    a_duty: assert property (p_duty) else $error("burst on time long");
    property p_max_on; on_q <= MAX_ON; endproperty
    a_max_on: assert property (p_max_on) else $error("on time long");
    property p_period; $rose(gate_drive) && run_q |-> per_q == 16'hfa0;
    endproperty
    a_period: assert property (p_period) else $error("bad period");
    property p_pause; burst_active && !bias_en |-> !gate_drive; endproperty
    a_pause: assert property (p_pause) else $error("gate in pause");
    property p_resume; (burst_active && fb_above_upper) [*4] |-> bias_en;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume");
    property p_sw;
        (gate_drive && cs_above_short_winding) [*3] |-> ##[0:2] latched_off;
    endproperty
    a_sw: assert property (p_sw) else $error("no latch off");
    property p_hold; latched_off |=> latched_off; endproperty
    a_hold: assert property (p_hold) else $error("latch left");
    property p_lgate; latched_off |-> !gate_drive && !burst_active;
    endproperty
    a_lgate: assert property (p_lgate) else $error("gate latched");
    property p_load; updn_load |-> updn_load_val == 3'h1 ##1 !updn_load;
    endproperty
    a_load: assert property (p_load) else $error("bad load");
    property p_cell; (latched_off && vcc_below_turnoff) [*4] |-> startup_cell_en;
    endproperty
    a_cell: assert property (p_cell) else $error("cell off");
    c_run: cover property ($rose(gate_drive) && run_q);
    c_load: cover property (updn_load);
    c_latch: cover property ($rose(latched_off));
endmodule
bind burst_prot_ctrl burst_prot_monitor #(.MAX_ON(MAX_ON)) mon_u (.*);

// file: tb/sense_model.sv
/*
 current sense comparator: ramp against the burst limit.
 assumes the bench sets ramp while the gate is low.
*/
`timescale 1ns/1ps
module sense_model (
    // clock and gate
    input wire core_clk,
    input wire gate_drive,
    // ramp length in cycles
    input wire [11:0] ramp,
    // comparator
    output wire cs_above_burst_limit
);
    reg [11:0] cnt_q;
    // current flows only while the switch conducts
    always @(posedge core_clk) begin
        cnt_q <= gate_drive ? cnt_q + 12'h1 : 12'h0;
    end
    assign cs_above_burst_limit = gate_drive && cnt_q >= ramp;
endmodule

// file: tb/testbench.sv
/*
 self-checking bench for burst_prot_ctrl.
 assumes 200 MHz core_clk, overload and entry blanking counts shortened by parameters.
*/
`timescale 1ns/1ps
module testbench;
    reg core_clk = 1'b0;
    reg resetn = 1'b0;
    reg fb_below_entry, fb_above_upper, fb_below_lower, fb_above_exit;
    reg fb_pulled_high, cs_above_short_winding, zc_above_ovp;
    reg vcc_below_turnoff, vcc_above_turnon, vcc_overvoltage, over_temp;
    reg norm_gate_on, norm_gate_off, saw_load;
    reg [2:0] updn_count;
    reg [11:0] ramp, w;
    reg [5:0] st_q[$];
    reg [11:0] w_q[$];
    wire cs_above_burst_limit, gate_drive, startup_cell_en, burst_active;
    wire bias_en, updn_load, latched_off, auto_restart;
    wire [2:0] updn_load_val;
    wire [5:0] st = {saw_load, burst_active, bias_en, latched_off,
        auto_restart, startup_cell_en};
    integer n_mismatch, checks_done, cyc, seed, i;
    event ev;
    burst_prot_ctrl #(.OVERLOAD_CYC(50), .ENTRY_CYC(20),
        .MAX_ON(3000)) dut_u (.*);
    sense_model sense_u (.core_clk(core_clk), .gate_drive(gate_drive),
        .ramp(ramp), .cs_above_burst_limit(cs_above_burst_limit));
    always #2.5 core_clk = ~core_clk;
    task cmp(input [11:0] e, input [11:0] g);
        checks_done = checks_done + 1;
        if (e !== g) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task chk(input integer n, input [5:0] e);
        repeat (n) @(negedge core_clk);
        st_q.push_back(e);
        -> ev;
    endtask
    task complete_run;
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(ev) cmp({6'h0, st_q.pop_front()}, {6'h0, st});
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (updn_load && updn_load_val === 3'h1) saw_load <= 1'b1;
        if (gate_drive) w <= w + 12'h1;
        else begin
            if (w != 12'h0 && w_q.size() > 0) cmp(w_q.pop_front(), w);
            w <= 12'h0;
        end
        if (cyc == 60000) begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end
    end
    initial begin
        {fb_below_entry, fb_above_upper, fb_below_lower, fb_above_exit} = 4'h0;
        {fb_pulled_high, cs_above_short_winding, zc_above_ovp} = 3'h0;
        {vcc_above_turnon, vcc_overvoltage, over_temp} = 3'h0;
        {norm_gate_on, norm_gate_off, saw_load} = 3'h0;
        vcc_below_turnoff = 1'b1;
        updn_count = 3'h6;
        ramp = 12'h0;
        w = 12'h0;
        {n_mismatch, checks_done, cyc} = 0;
        seed = 32'h93208e88;
        repeat (5) @(negedge core_clk);
        resetn = 1'b1;
        chk(6, 6'h03);
        {vcc_below_turnoff, vcc_above_turnon} = 2'h1;
        chk(6, 6'h08);
        {vcc_below_turnoff, vcc_above_turnon} = 2'h2;
        chk(6, 6'h03);
        {vcc_below_turnoff, vcc_above_turnon} = 2'h1;
        fb_below_entry = 1'b1;
        chk(40, 6'h08);
        fb_below_entry = 1'b0;
        updn_count = 3'h7;
        chk(6, 6'h08);
        fb_below_entry = 1'b1;
        chk(10, 6'h08);
        chk(20, 6'h10);
        {fb_below_entry, fb_above_upper} = 2'h1;
        chk(6, 6'h18);
        // widths cover the limit, and half period when the limit never comes
        for (i = 0; i < 4; i = i + 1) begin
            while (gate_drive) @(negedge core_clk);
            ramp = (i == 3) ? 12'h9c4 : 12'h14 + $unsigned($random(seed)) % 32'h258;
            w_q.push_back(ramp > 12'h7cd ? 12'h7d0 : ramp + 12'h3);
            @(posedge gate_drive);
            @(negedge gate_drive);
            @(negedge core_clk);
        end
        {fb_above_upper, fb_below_lower} = 2'h1;
        chk(6, 6'h10);
        {fb_below_lower, fb_above_exit} = 2'h1;
        chk(6, 6'h28);
        {fb_above_exit, vcc_above_turnon, fb_pulled_high} = 3'h1;
        chk(40, 6'h28);
        chk(20, 6'h22);
        {fb_pulled_high, vcc_above_turnon} = 2'h1;
        chk(6, 6'h28);
        over_temp = 1'b1;
        chk(6, 6'h22);
        over_temp = 1'b0;
        chk(6, 6'h28);
        norm_gate_on = 1'b1;
        @(negedge core_clk) norm_gate_on = 1'b0;
        while (!gate_drive) @(negedge core_clk);
        cs_above_short_winding = 1'b1;
        chk(6, 6'h24);
        {cs_above_short_winding, vcc_above_turnon, vcc_below_turnoff} = 3'h1;
        chk(6, 6'h25);
        vcc_below_turnoff = 1'b0;
        chk(6, 6'h25);
        vcc_above_turnon = 1'b1;
        chk(6, 6'h24);
        // mid-run reset is the only way out of latched off
        resetn = 1'b0;
        chk(3, 6'h20);
        resetn = 1'b1;
        chk(6, 6'h28);
        norm_gate_on = 1'b1;
        w_q.push_back(12'hbb8);
        @(negedge core_clk) norm_gate_on = 1'b0;
        @(negedge gate_drive);
        @(negedge core_clk);
        vcc_overvoltage = 1'b1;
        chk(6, 6'h22);
        vcc_overvoltage = 1'b0;
        chk(6, 6'h28);
        zc_above_ovp = 1'b1;
        chk(150, 6'h28);
        chk(60, 6'h24);
        complete_run;
    end
endmodule
